// ### pkg/pscp_cfg.svh
`ifndef PSCP_CFG_SVH
`define PSCP_CFG_SVH

// shift register length per device
`define PSCP_WORD_W        16
// control word field positions
`define PSCP_BIT_SERVO_DIS 15
`define PSCP_BIT_CM_EN     14
`define PSCP_BIT_ZC_EN     13
`define PSCP_BIT_OR_SEL    12
`define PSCP_BIT_GPO_LO    8
`define PSCP_GAIN_LO       0
`define PSCP_GAIN_W        6
// control word value after reset
`define PSCP_WORD_RST      16'h0000
// axi-lite register byte addresses
`define PSCP_ADDR_CTRL     32'h0000_0000
`define PSCP_ADDR_STAT     32'h0000_0004
`define PSCP_ADDR_SHIFT    32'h0000_0008
// axi response codes
`define PSCP_RESP_OKAY     2'h0
`define PSCP_RESP_SLVERR   2'h2

`endif

// ### pkg/pscp_pkg.sv
`include "pscp_cfg.svh"

package pscp_pkg;

  typedef logic [`PSCP_WORD_W-1:0] pscp_word_t;

  // decoded control word outputs
  typedef struct packed {
    logic       servo_disable;
    logic       common_mode_servo_en;
    logic       zero_cross_en;
    logic       overrange_low_sel;
    logic [3:0] gen_out;
    logic [5:0] gain_code;
  } pscp_ctrl_t;

  // serial port pins
  typedef struct packed {
    logic serial_out;
    logic serial_out_oe;
  } pscp_sout_t;

endpackage

// ### core/pscp_serial_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "pscp_cfg.svh"

module pscp_serial_port #(
  parameter int WORD_W = `PSCP_WORD_W
) (
  // clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // serial pins, asynchronous to aclk
  input  wire logic                 select_n,
  input  wire logic                 shift_clk,
  input  wire logic                 serial_in,
  output pscp_pkg::pscp_sout_t      sout,
  // decoded control outputs
  output pscp_pkg::pscp_ctrl_t      ctrl,
  // axi4-lite write address
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_awaddr,
  // axi4-lite write data
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  // axi4-lite write response
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output logic [1:0]                s_axi_bresp,
  // axi4-lite read address
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  input  wire logic [31:0]          s_axi_araddr,
  // axi4-lite read data
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp
);
  import pscp_pkg::*;

  // two-stage synchronisers for the three pins
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic [2:0] prev_q;
  // reset to the idle pin levels (select high, clock and data low) so the
  // edge detectors see no false edge right after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 3'h4;
      sync_q <= 3'h4;
      prev_q <= 3'h4;
    end else begin
      meta_q <= {select_n, shift_clk, serial_in};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  wire logic sel_n_s  = sync_q[2];
  wire logic sck_s    = sync_q[1];
  wire logic sdi_s    = sync_q[0];
  wire logic active   = !sel_n_s && !prev_q[2];
  wire logic sck_rise = active && sck_s && !prev_q[1];
  wire logic sck_fall = active && !sck_s && prev_q[1];
  wire logic sel_rise = sel_n_s && !prev_q[2];

  logic [WORD_W-1:0] shift_q;
  logic [WORD_W-1:0] word_q;
  logic              sout_q;
  logic              oe_q;
  logic [7:0]        clk_cnt_q;
  logic [7:0]        last_cnt_q;

  // software may preload the shift register for read-back tests
  logic              sw_load;
  logic [WORD_W-1:0] sw_word;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_q <= '0;
    end else if (sck_rise) begin
      shift_q <= {shift_q[WORD_W-2:0], sdi_s};
    end else if (sw_load) begin
      shift_q <= sw_word;
    end
  end

  // msb-first: last stage is the top bit, so N devices form 16 x N chain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sout_q <= 1'b0;
    end else if (sck_fall || (sel_n_s == 1'b0 && prev_q[2])) begin
      sout_q <= shift_q[WORD_W-1];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= !sel_n_s;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word_q <= `PSCP_WORD_RST;
    end else if (sel_rise) begin
      word_q <= shift_q;
    end
  end

  // clock counter per frame, visible in status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_cnt_q  <= 8'h00;
      last_cnt_q <= 8'h00;
    end else if (sel_rise) begin
      last_cnt_q <= clk_cnt_q;
      clk_cnt_q  <= 8'h00;
    end else if (sck_rise) begin
      clk_cnt_q  <= clk_cnt_q + 8'h01;
    end
  end

  assign sout.serial_out    = sout_q;
  assign sout.serial_out_oe = oe_q;
  assign ctrl.servo_disable        = word_q[`PSCP_BIT_SERVO_DIS];
  assign ctrl.common_mode_servo_en = word_q[`PSCP_BIT_CM_EN];
  assign ctrl.zero_cross_en        = word_q[`PSCP_BIT_ZC_EN];
  assign ctrl.overrange_low_sel    = word_q[`PSCP_BIT_OR_SEL];
  assign ctrl.gen_out   = word_q[`PSCP_BIT_GPO_LO +: 4];
  assign ctrl.gain_code = word_q[`PSCP_GAIN_LO +: `PSCP_GAIN_W];

  // axi4-lite write: address and data taken in either order
  logic        aw_have_q;
  logic        w_have_q;
  logic [31:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  wire logic aw_fire  = s_axi_awvalid && s_axi_awready;
  wire logic w_fire   = s_axi_wvalid && s_axi_wready;
  wire logic wr_go    = aw_have_q && w_have_q;
  wire logic wr_hit   = aw_addr_q == `PSCP_ADDR_SHIFT;
  // a preload during a live frame would corrupt the bits being shifted
  assign sw_load = wr_go && wr_hit && !active;
  assign sw_word = w_data_q[WORD_W-1:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 32'h0000_0000;
      w_data_q  <= 32'h0000_0000;
      bvalid_q  <= 1'b0;
      bresp_q   <= `PSCP_RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? `PSCP_RESP_OKAY : `PSCP_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // axi4-lite read
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  assign s_axi_arready = !rvalid_q;
  wire logic ar_fire = s_axi_arvalid && s_axi_arready;
  wire logic rd_ctrl  = s_axi_araddr == `PSCP_ADDR_CTRL;
  wire logic rd_stat  = s_axi_araddr == `PSCP_ADDR_STAT;
  wire logic rd_shift = s_axi_araddr == `PSCP_ADDR_SHIFT;
  wire logic [31:0] stat_word = {14'h0000, last_cnt_q, clk_cnt_q,
                                 !sel_n_s, oe_q};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `PSCP_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rresp_q  <= `PSCP_RESP_OKAY;
      if (rd_ctrl) begin
        rdata_q <= {16'h0000, word_q};
      end else if (rd_stat) begin
        rdata_q <= stat_word;
      end else if (rd_shift) begin
        rdata_q <= {16'h0000, shift_q};
      end else begin
        rdata_q <= 32'h0000_0000;
        rresp_q <= `PSCP_RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule
`default_nettype wire

// ### sim/pscp_host.sv
`timescale 1ns/10ps
`default_nettype none
module pscp_host (
  // link pins
  output logic     select_n,
  output logic     shift_clk,
  output logic     serial_in,
  // read-back from the device
  input wire logic serial_out
);
  initial begin
    select_n = 1'h1;
    shift_clk = 1'h0;
    serial_in = 1'h0;
  end
  // junk clocks while deselected must not move the device
  task automatic frame(input int n, input logic [31:0] d, input bit junk,
                       output logic [31:0] q);
    #3;
    if (junk) repeat (2) begin
      #40 shift_clk = 1'h1;
      #40 shift_clk = 1'h0;
    end
    select_n = 1'h0;
    #60;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = d[i];
      #40 shift_clk = 1'h1;
      // sample late in the high phase: output moves after the fall
      #40 q[i] = serial_out;
      shift_clk = 1'h0;
    end
    serial_in = ~serial_in;
    #40 select_n = 1'h1;
    #100;
  endtask
endmodule
`default_nettype wire

// ### sim/pscp_serial_port_sva.sv
`timescale 1ns/10ps
`default_nettype none
module pscp_chk (
  // clock and reset
  input wire logic                 aclk,
  input wire logic                 aresetn,
  // link pins and outputs
  input wire logic                 select_n,
  input wire logic                 shift_clk,
  input wire pscp_pkg::pscp_sout_t sout,
  input wire pscp_pkg::pscp_ctrl_t ctrl
);
  import pscp_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_oe_off;
    select_n [*5] |-> !sout.serial_out_oe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("output driven while deselected");
  property p_oe_on;
    !select_n [*5] |-> sout.serial_out_oe;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("output floats while selected");
  property p_oe_drop;
    $rose(select_n) |-> ##[1:5] !sout.serial_out_oe;
  endproperty
  a_oe_drop: assert property (p_oe_drop)
    else $error("output enable late to drop");
  property p_oe_rise;
    $fell(select_n) |-> ##[1:5] sout.serial_out_oe;
  endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("output enable late to rise");
  property p_latch;
    $changed(ctrl) |-> $past(select_n, 2) && !$past(select_n, 7);
  endproperty
  a_latch: assert property (p_latch)
    else $error("control word moved without select rise");
  property p_still;
    select_n [*8] |-> $stable(ctrl);
  endproperty
  a_still: assert property (p_still)
    else $error("control word moved while deselected");
  property p_hold;
    !select_n [*4] |-> $stable(ctrl);
  endproperty
  a_hold: assert property (p_hold)
    else $error("control word moved during a frame");
  property p_fall;
    $changed(sout.serial_out) && $past(sout.serial_out_oe, 2)
      |-> !$past(shift_clk, 2);
  endproperty
  a_fall: assert property (p_fall)
    else $error("serial output moved off the falling edge");
endmodule
bind pscp_serial_port pscp_chk pscp_chk_i (.aclk, .aresetn, .select_n,
  .shift_clk, .sout, .ctrl);
`default_nettype wire

// ### sim/test_preamp_serial_control_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "pscp_cfg.svh"
module test_preamp_serial_control_port;
  import pscp_pkg::*;
  logic        aclk, aresetn, select_n, shift_clk, serial_in;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, w, q;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] wm;
  logic [31:0] e;
  bit          mdl[$];
  int          n;
  pscp_sout_t  sout;
  pscp_ctrl_t  ctrl;
  int          n_fail, checked;
  pscp_serial_port pscp_serial_port_i (.aclk, .aresetn, .select_n,
    .shift_clk, .serial_in, .sout, .ctrl, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp);
  pscp_host pscp_host_i (.select_n, .shift_clk, .serial_in,
    .serial_out(sout.serial_out_oe ? sout.serial_out : 1'hZ));
  always #5 aclk = ~aclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk(32'(s_axi_bresp), 32'(r));
  endtask
  task automatic rd(input logic [31:0] a, d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, d);
    chk(32'(s_axi_rresp), 32'(r));
  endtask
  task automatic stop_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    stop_test();
  end
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    void'($urandom(44));
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (3) @(posedge aclk);
    wr(`PSCP_ADDR_CTRL, 32'hFFFF, `PSCP_RESP_SLVERR);
    rd(`PSCP_ADDR_CTRL, 32'h0, `PSCP_RESP_OKAY);
    rd(32'h10, 32'h0, `PSCP_RESP_SLVERR);
    w = $urandom;
    wr(`PSCP_ADDR_SHIFT, w, `PSCP_RESP_OKAY);
    rd(`PSCP_ADDR_SHIFT, 32'(w[15:0]), `PSCP_RESP_OKAY);
    // model of one 16-stage chain; the front feeds serial_out
    for (int i = 15; i >= 0; i--) begin
      mdl.push_back(w[i]);
    end
    // first frame spans two devices' worth of bits
    for (int k = 0; k < 6; k++) begin
      w = $urandom;
      n = (k == 0) ? 32 : 16;
      e = 32'h0000_0000;
      for (int i = n - 1; i >= 0; i--) begin
        e[i] = mdl.pop_front();
        mdl.push_back(w[i]);
      end
      for (int i = 0; i < 16; i++) begin
        wm[15 - i] = mdl[i];
      end
      pscp_host_i.frame(n, w, k == 2, q);
      repeat (8) @(posedge aclk);
      if (k == 0) chk(q, e);
      else chk(32'(q[15:0]), e);
      chk(32'(ctrl), 32'({wm[15:8], wm[5:0]}));
      rd(`PSCP_ADDR_CTRL, 32'(wm), `PSCP_RESP_OKAY);
    end
    // last frame had sixteen clocks; select and enable are idle now
    rd(`PSCP_ADDR_STAT, 32'h0000_4000, `PSCP_RESP_OKAY);
    stop_test();
  end
endmodule
`default_nettype wire
